// file: kwp_pkg.sv
// shared constants for the key wake-up ports block
package kwp_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned PORT_W = 8;
   localparam logic [ADDR_W-1:0] OFS_DIR_G = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_DIR_H = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_EN_G = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_EN_H = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_FLAG_G = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_FLAG_H = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_DATA_G = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_DATA_H = 8'h1c;
   localparam logic [ADDR_W-1:0] OFS_PINS = 8'h20;
   localparam logic [PORT_W-1:0] RST_REG = 8'h00;
   localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;
   localparam int unsigned I2C_SEL_BIT = 7;
   localparam int unsigned SDA_BIT = 6;
   localparam int unsigned SCL_BIT = 7;
   localparam int unsigned FLAG_G_TOP = 7;
   // filter oscillator period in bus clocks and its three sample points
   localparam int unsigned FILT_PERIOD = 6;
   localparam logic [2:0] FILT_LAST = 3'h5;
   localparam logic [2:0] FILT_S0 = 3'h1;
   localparam logic [2:0] FILT_S1 = 3'h3;
   localparam logic [2:0] FILT_S2 = 3'h5;
   localparam logic [1:0] FILT_MAJ = 2'h2;
endpackage : kwp_pkg

// file: kwp_sync_edge.sv
// pin synchroniser and falling-edge detector, two sync stages and one edge register per pin
`timescale 1ns/1ps
`default_nettype none
module kwp_sync_edge (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [15:0] i_pins,
   output logic [15:0] o_level,
   output logic [15:0] o_fall
);
   import kwp_pkg::*;
   genvar b;
   generate
      for (b = 0; b < 16; b = b + 1) begin : g_pin
         logic meta;
         logic lvl;
         logic prev;
         always_ff @(posedge i_clock or posedge i_rst) begin
            if (i_rst) begin
               meta <= 1'b1;
               lvl <= 1'b1;
               prev <= 1'b1;
            end else begin
               meta <= i_pins[b];
               lvl <= meta;
               prev <= lvl;
            end
         end
         assign o_level[b] = lvl;
         // high-to-low only; direction does not matter, the pad is read back
         assign o_fall[b] = prev & ~lvl; // RULE_01
      end
   endgenerate
endmodule : kwp_sync_edge
`default_nettype wire

// file: kwp_stop_filter.sv
// shared majority-vote wake-up filter, active in stop mode only
`timescale 1ns/1ps
`default_nettype none
module kwp_stop_filter (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_stop,
   input wire logic i_trigger,
   input wire logic i_level,
   output logic o_valid
);
   import kwp_pkg::*;
   logic running;
   logic [2:0] phase;
   logic [1:0] votes;
   logic sample;
   logic [1:0] next_votes;
   assign sample = (phase == FILT_S0) | (phase == FILT_S1)
      | (phase == FILT_S2);
   always_comb begin
      next_votes = votes;
      if (sample && i_level) begin
         next_votes = votes + 2'h1;
      end
   end
   // oscillator starts on an enabled edge; any enabled pin feeds it, so
   // close pulses on different pins may merge into one accept
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         running <= 1'b0;
         phase <= 3'h0;
         votes <= 2'h0;
         o_valid <= 1'b0;
      end else if (!i_stop) begin // RULE_16
         running <= 1'b0;
         phase <= 3'h0;
         votes <= 2'h0;
         o_valid <= 1'b0;
      end else if (!running) begin
         running <= i_trigger; // RULE_17 RULE_19
         phase <= 3'h0;
         votes <= 2'h0;
         o_valid <= 1'b0;
      end else if (phase == FILT_LAST) begin
         running <= 1'b0;
         phase <= 3'h0;
         votes <= 2'h0;
         o_valid <= (next_votes >= FILT_MAJ); // RULE_18 RULE_20
      end else begin
         phase <= phase + 3'h1;
         votes <= next_votes;
         o_valid <= 1'b0;
      end
   end
   AST_FILTER_BYPASS: assert property ( // RULE_16
      @(posedge i_clock) disable iff (i_rst)
      !i_stop |=> !o_valid)
      else $error("filter accepted outside stop");
   AST_FILTER_START: assert property ( // RULE_17
      @(posedge i_clock) disable iff (i_rst)
      i_stop && !running && !i_trigger |=> !running)
      else $error("filter oscillator started with no trigger");
   AST_FILTER_MAJORITY: assert property ( // RULE_18
      @(posedge i_clock) disable iff (i_rst)
      o_valid |-> $past(next_votes) >= FILT_MAJ)
      else $error("filter accepted with fewer than two votes");
endmodule : kwp_stop_filter
`default_nettype wire

// file: kwp_ports.sv
// key wake-up ports g and h with apb register access
// Notes on behaviour
// RULE_01: wake-up only on falling pin edges
// RULE_02: irq when flag and its enable set
// RULE_03: fifteen sources share one interrupt output
// RULE_04: unclocked enabled-pin path to irq in stop
// RULE_05: edges detected whether pin is input or output
// RULE_06: pull-select pin high pulls up, low down
// RULE_07: direction bit 0 input, 1 output
// RULE_08: select bit picks plain edge or start
// RULE_09: pins 6,7 open-drain while start selected
// RULE_10: start needs sda fall while scl high
// RULE_11: enable bit 6 gates edge or start
// RULE_12: enable bits 0 disable, 1 enable
// RULE_13: flags set on falling edge, write-one clears
// RULE_14: port g flag bit 7 reads zero
// RULE_15: flag 6 records edge or start
// RULE_16: filter works only in stop mode
// RULE_17: enabled triggering edge starts filter oscillator
// RULE_18: two of three samples accept, set flag
// RULE_19: one filter shared by all enabled inputs
// RULE_20: closely spaced pulses may merge into one
// RULE_21: outside stop, synchronised edges set flags
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module kwp_ports (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [kwp_pkg::ADDR_W-1:0] paddr,
   input wire logic [kwp_pkg::DATA_W-1:0] pwdata,
   output logic [kwp_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic i_stop,
   input wire logic [kwp_pkg::PORT_W-1:0] i_port_g_pins,
   input wire logic [kwp_pkg::PORT_W-1:0] i_port_h_pins,
   output logic [kwp_pkg::PORT_W-1:0] o_port_g_out,
   output logic [kwp_pkg::PORT_W-1:0] o_port_g_oe_n,
   output logic [kwp_pkg::PORT_W-1:0] o_port_h_out,
   output logic [kwp_pkg::PORT_W-1:0] o_port_h_oe_n,
   input wire logic i_port_g_pull_select,
   input wire logic i_port_h_pull_select,
   output logic o_port_g_pull_up,
   output logic o_port_g_pull_down,
   output logic o_port_h_pull_up,
   output logic o_port_h_pull_down,
   output logic o_wake_irq
);
   import kwp_pkg::*;

   logic [PORT_W-1:0] port_g_direction;
   logic [PORT_W-1:0] port_h_direction;
   logic [PORT_W-1:0] port_g_wake_enable;
   logic [PORT_W-1:0] port_h_wake_enable;
   logic [PORT_W-1:0] port_g_wake_flags;
   logic [PORT_W-1:0] port_h_wake_flags;
   logic [PORT_W-1:0] port_g_data;
   logic [PORT_W-1:0] port_h_data;
   logic [PORT_W-1:0] stop_pend_g;
   logic [PORT_W-1:0] stop_pend_h;
   logic ack;
   logic [15:0] lvl;
   logic [15:0] fall;
   logic [PORT_W-1:0] lvl_g;
   logic [PORT_W-1:0] lvl_h;
   logic [PORT_W-1:0] fall_g;
   logic [PORT_W-1:0] fall_h;
   logic i2c_start_wake_select;
   logic [PORT_W-1:0] en_g_mask;
   logic [PORT_W-1:0] ev_g;
   logic [PORT_W-1:0] set_g;
   logic [PORT_W-1:0] set_h;
   logic [PORT_W-1:0] clr_g;
   logic [PORT_W-1:0] clr_h;
   logic [PORT_W-1:0] next_flags_g;
   logic [PORT_W-1:0] next_flags_h;
   logic setup;
   logic wr;
   logic mapped;
   logic filt_valid;
   logic filt_trigger;
   logic filt_level;
   logic async_wake;
   logic pending_irq;
   logic [DATA_W-1:0] next_rdata;

   kwp_sync_edge u_sync (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_pins({i_port_h_pins, i_port_g_pins}),
      .o_level(lvl),
      .o_fall(fall)
   );

   assign lvl_g = lvl[PORT_W-1:0];
   assign lvl_h = lvl[2*PORT_W-1:PORT_W];
   assign fall_g = fall[PORT_W-1:0];
   assign fall_h = fall[2*PORT_W-1:PORT_W];
   assign i2c_start_wake_select = port_g_wake_enable[I2C_SEL_BIT];

   // bit 7 of the g enable register is the start-detect select, not a pin
   always_comb begin
      en_g_mask = port_g_wake_enable;
      en_g_mask[FLAG_G_TOP] = 1'b0; // RULE_12
   end

   // per-pin events; pin 6 turns into start detect when selected
   always_comb begin
      ev_g = fall_g; // RULE_05
      ev_g[FLAG_G_TOP] = 1'b0; // RULE_14
      if (i2c_start_wake_select) begin
         ev_g[SDA_BIT] = fall_g[SDA_BIT] & lvl_g[SCL_BIT]; // RULE_08 RULE_10
      end
   end

   // outside stop the edges set flags directly; in stop they wait for
   // the filter to accept, and short glitches are then dropped
   assign filt_trigger = |(ev_g & en_g_mask) | |(fall_h & port_h_wake_enable);
   assign filt_level = |(~lvl_g & en_g_mask) | |(~lvl_h & port_h_wake_enable);

   kwp_stop_filter u_filter (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_stop(i_stop),
      .i_trigger(filt_trigger),
      .i_level(filt_level),
      .o_valid(filt_valid)
   );

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         stop_pend_g <= RST_REG;
         stop_pend_h <= RST_REG;
      end else if (!i_stop || filt_valid) begin
         stop_pend_g <= RST_REG;
         stop_pend_h <= RST_REG;
      end else begin
         stop_pend_g <= stop_pend_g | (ev_g & en_g_mask); // RULE_19
         stop_pend_h <= stop_pend_h | (fall_h & port_h_wake_enable);
      end
   end

   always_comb begin
      if (i_stop) begin
         set_g = filt_valid ? (stop_pend_g | (ev_g & en_g_mask)) : RST_REG;
         set_h = filt_valid ? (stop_pend_h | (fall_h & port_h_wake_enable))
            : RST_REG; // RULE_18
      end else begin
         set_g = ev_g; // RULE_21 RULE_15
         set_h = fall_h; // RULE_21
      end
   end

   // apb: setup cycle arms the answer, access completes one cycle later
   assign setup = psel & ~penable;
   assign pready = psel & penable & ack;
   assign wr = pready & pwrite;
   assign mapped = (paddr == OFS_DIR_G) | (paddr == OFS_DIR_H)
      | (paddr == OFS_EN_G) | (paddr == OFS_EN_H) | (paddr == OFS_FLAG_G)
      | (paddr == OFS_FLAG_H) | (paddr == OFS_DATA_G)
      | (paddr == OFS_DATA_H) | (paddr == OFS_PINS);

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         ack <= 1'b0;
      end else begin
         ack <= setup;
      end
   end

   always_comb begin
      next_rdata = RD_ZERO;
      case (paddr)
         OFS_DIR_G: next_rdata[PORT_W-1:0] = port_g_direction;
         OFS_DIR_H: next_rdata[PORT_W-1:0] = port_h_direction;
         OFS_EN_G: next_rdata[PORT_W-1:0] = port_g_wake_enable;
         OFS_EN_H: next_rdata[PORT_W-1:0] = port_h_wake_enable;
         OFS_FLAG_G: next_rdata[PORT_W-1:0] = port_g_wake_flags; // RULE_14
         OFS_FLAG_H: next_rdata[PORT_W-1:0] = port_h_wake_flags;
         OFS_DATA_G: next_rdata[PORT_W-1:0] = port_g_data;
         OFS_DATA_H: next_rdata[PORT_W-1:0] = port_h_data;
         OFS_PINS: next_rdata[2*PORT_W-1:0] = lvl;
         default: next_rdata = RD_ZERO;
      endcase
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         prdata <= RD_ZERO;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata <= pwrite ? RD_ZERO : next_rdata;
         pslverr <= ~mapped;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         port_g_direction <= RST_REG;
         port_h_direction <= RST_REG;
         port_g_data <= RST_REG;
         port_h_data <= RST_REG;
      end else if (wr) begin
         if (paddr == OFS_DIR_G) begin
            port_g_direction <= pwdata[PORT_W-1:0]; // RULE_07
         end
         if (paddr == OFS_DIR_H) begin
            port_h_direction <= pwdata[PORT_W-1:0]; // RULE_07
         end
         if (paddr == OFS_DATA_G) begin
            port_g_data <= pwdata[PORT_W-1:0];
         end
         if (paddr == OFS_DATA_H) begin
            port_h_data <= pwdata[PORT_W-1:0];
         end
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         port_g_wake_enable <= RST_REG;
         port_h_wake_enable <= RST_REG;
      end else if (wr) begin
         if (paddr == OFS_EN_G) begin
            port_g_wake_enable <= pwdata[PORT_W-1:0]; // RULE_11 RULE_12
         end
         if (paddr == OFS_EN_H) begin
            port_h_wake_enable <= pwdata[PORT_W-1:0]; // RULE_12
         end
      end
   end

   // write-one-to-clear; a set in the same cycle wins over the clear
   assign clr_g = (wr && paddr == OFS_FLAG_G) ? pwdata[PORT_W-1:0] : RST_REG;
   assign clr_h = (wr && paddr == OFS_FLAG_H) ? pwdata[PORT_W-1:0] : RST_REG;
   always_comb begin
      next_flags_g = (port_g_wake_flags & ~clr_g) | set_g; // RULE_13
      next_flags_g[FLAG_G_TOP] = 1'b0; // RULE_14
      next_flags_h = (port_h_wake_flags & ~clr_h) | set_h; // RULE_13
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         port_g_wake_flags <= RST_REG;
         port_h_wake_flags <= RST_REG;
      end else begin
         port_g_wake_flags <= next_flags_g;
         port_h_wake_flags <= next_flags_h;
      end
   end

   // pins: open-drain on 6 and 7 while start detect is selected
   always_comb begin
      o_port_g_out = port_g_data;
      o_port_g_oe_n = ~port_g_direction; // RULE_07
      if (i2c_start_wake_select) begin
         o_port_g_out[SDA_BIT] = 1'b0; // RULE_09
         o_port_g_out[SCL_BIT] = 1'b0; // RULE_09
         o_port_g_oe_n[SDA_BIT] = ~(port_g_direction[SDA_BIT]
            & ~port_g_data[SDA_BIT]); // RULE_09
         o_port_g_oe_n[SCL_BIT] = ~(port_g_direction[SCL_BIT]
            & ~port_g_data[SCL_BIT]); // RULE_09
      end
   end
   assign o_port_h_out = port_h_data;
   assign o_port_h_oe_n = ~port_h_direction; // RULE_07

   assign o_port_g_pull_up = i_port_g_pull_select; // RULE_06
   assign o_port_g_pull_down = ~i_port_g_pull_select; // RULE_06
   assign o_port_h_pull_up = i_port_h_pull_select; // RULE_06
   assign o_port_h_pull_down = ~i_port_h_pull_select; // RULE_06

   // the raw-pin term needs no clock, so a stopped part still wakes;
   // it is a level, held while any enabled pin stays low
   assign async_wake = i_stop & (|(~i_port_g_pins & en_g_mask)
      | |(~i_port_h_pins & port_h_wake_enable)); // RULE_04
   assign pending_irq = |(port_g_wake_flags & en_g_mask)
      | |(port_h_wake_flags & port_h_wake_enable); // RULE_02
   assign o_wake_irq = pending_irq | async_wake; // RULE_03

   AST_IRQ_FROM_FLAGS: assert property ( // RULE_02
      @(posedge i_clock) disable iff (i_rst)
      (|(port_h_wake_flags & port_h_wake_enable)) |-> o_wake_irq)
      else $error("enabled flag without interrupt");
   AST_IRQ_FROM_G: assert property ( // RULE_02
      @(posedge i_clock) disable iff (i_rst)
      (|(port_g_wake_flags & en_g_mask)) |-> o_wake_irq)
      else $error("enabled port g flag without interrupt");
   AST_IRQ_QUIET: assert property ( // RULE_03
      @(posedge i_clock) disable iff (i_rst)
      !i_stop && !(|(port_g_wake_flags & en_g_mask))
      && !(|(port_h_wake_flags & port_h_wake_enable)) |-> !o_wake_irq)
      else $error("interrupt without an enabled flag");
   AST_ASYNC_WAKE: assert property ( // RULE_04
      @(posedge i_clock) disable iff (i_rst)
      i_stop && port_h_wake_enable[0] && !i_port_h_pins[0] |-> o_wake_irq)
      else $error("enabled low pin in stop did not raise interrupt");
   AST_FLAG7_ZERO: assert property ( // RULE_14
      @(posedge i_clock) disable iff (i_rst)
      !port_g_wake_flags[FLAG_G_TOP])
      else $error("port g flag bit 7 set");
   AST_EDGE_SETS: assert property ( // RULE_21
      @(posedge i_clock) disable iff (i_rst)
      !i_stop && fall_h[0] |=> port_h_wake_flags[0])
      else $error("falling edge did not set flag");
   AST_PIN6_PLAIN: assert property ( // RULE_08
      @(posedge i_clock) disable iff (i_rst)
      !i_stop && !i2c_start_wake_select && fall_g[SDA_BIT]
      |=> port_g_wake_flags[SDA_BIT])
      else $error("plain pin 6 edge did not set flag");
   AST_START_SETS: assert property ( // RULE_15
      @(posedge i_clock) disable iff (i_rst)
      !i_stop && i2c_start_wake_select && fall_g[SDA_BIT] && lvl_g[SCL_BIT]
      |=> port_g_wake_flags[SDA_BIT])
      else $error("start condition did not set flag 6");
   AST_W1C: assert property ( // RULE_13
      @(posedge i_clock) disable iff (i_rst)
      wr && paddr == OFS_FLAG_H && pwdata[0] && !set_h[0]
      |=> !port_h_wake_flags[0])
      else $error("write one did not clear flag");
   AST_W0_KEEPS: assert property ( // RULE_13
      @(posedge i_clock) disable iff (i_rst)
      wr && paddr == OFS_FLAG_H && !pwdata[0] && port_h_wake_flags[0]
      |=> port_h_wake_flags[0])
      else $error("write zero cleared a flag");
   AST_START_NEEDS_SCL: assert property ( // RULE_10
      @(posedge i_clock) disable iff (i_rst)
      !i_stop && i2c_start_wake_select && !lvl_g[SCL_BIT]
      && !port_g_wake_flags[SDA_BIT] && !clr_g[SDA_BIT]
      |=> !port_g_wake_flags[SDA_BIT])
      else $error("start flagged with scl low");
   AST_OPEN_DRAIN: assert property ( // RULE_09
      @(posedge i_clock) disable iff (i_rst)
      i2c_start_wake_select |-> o_port_g_out[SCL_BIT:SDA_BIT] == 2'h0)
      else $error("start-detect pins driven high");
   AST_DIR_WRITE: assert property ( // RULE_07
      @(posedge i_clock) disable iff (i_rst)
      wr && paddr == OFS_DIR_H |=> o_port_h_oe_n == ~$past(pwdata[7:0]))
      else $error("direction write did not reach pins");
   AST_DIR_G_WRITE: assert property ( // RULE_07
      @(posedge i_clock) disable iff (i_rst)
      wr && paddr == OFS_DIR_G
      |=> port_g_direction == $past(pwdata[PORT_W-1:0]))
      else $error("port g direction write lost");
   AST_STOP_HOLD: assert property ( // RULE_16
      @(posedge i_clock) disable iff (i_rst)
      i_stop && !filt_valid && !(|clr_h)
      |=> port_h_wake_flags == $past(port_h_wake_flags))
      else $error("flag set in stop without filter accept");
   AST_STOP_ACCEPT: assert property ( // RULE_18
      @(posedge i_clock) disable iff (i_rst)
      i_stop && filt_valid && stop_pend_h[0] |=> port_h_wake_flags[0])
      else $error("accepted pulse did not set its flag");
endmodule : kwp_ports
`default_nettype wire

// file: kwp_key_model.sv
// far-side model: keys and i2c lines on ports g and h, with pull resistors
`timescale 1ns/1ps
`default_nettype none
module kwp_key_model (
   input wire logic [kwp_pkg::PORT_W-1:0] i_press_g,
   input wire logic [kwp_pkg::PORT_W-1:0] i_press_h,
   input wire logic [kwp_pkg::PORT_W-1:0] i_out_g,
   input wire logic [kwp_pkg::PORT_W-1:0] i_oe_n_g,
   input wire logic [kwp_pkg::PORT_W-1:0] i_out_h,
   input wire logic [kwp_pkg::PORT_W-1:0] i_oe_n_h,
   input wire logic i_pull_up_g,
   input wire logic i_pull_up_h,
   output logic [kwp_pkg::PORT_W-1:0] o_pins_g,
   output logic [kwp_pkg::PORT_W-1:0] o_pins_h
);
   import kwp_pkg::*;
   // a driven pin shows the device value; a released pin is pulled to the
   // selected rail unless a key or bus party grounds it
   always_comb begin
      o_pins_g = (~i_oe_n_g & i_out_g)
               | (i_oe_n_g & ~i_press_g & {PORT_W{i_pull_up_g}});
      o_pins_h = (~i_oe_n_h & i_out_h)
               | (i_oe_n_h & ~i_press_h & {PORT_W{i_pull_up_h}});
   end
endmodule : kwp_key_model
`default_nettype wire

// file: key_wakeup_ports_bench.sv
// self-checking bench for the key wake-up ports block
`timescale 1ns/1ps
`default_nettype none
module key_wakeup_ports_bench;
   import kwp_pkg::*;
   logic i_clock, i_rst, psel, penable, pwrite, pready, pslverr, i_stop;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0] pins_g, pins_h, out_g, oe_n_g, out_h, oe_n_h;
   logic [7:0] press_g, press_h;
   logic sel_g, sel_h, up_g, dn_g, up_h, dn_h, irq;
   int bad_count, n_tests;

   kwp_ports i_dut (.i_clock(i_clock), .i_rst(i_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .i_stop(i_stop),
      .i_port_g_pins(pins_g), .i_port_h_pins(pins_h),
      .o_port_g_out(out_g), .o_port_g_oe_n(oe_n_g), .o_port_h_out(out_h),
      .o_port_h_oe_n(oe_n_h), .i_port_g_pull_select(sel_g),
      .i_port_h_pull_select(sel_h), .o_port_g_pull_up(up_g),
      .o_port_g_pull_down(dn_g), .o_port_h_pull_up(up_h),
      .o_port_h_pull_down(dn_h), .o_wake_irq(irq));

   kwp_key_model i_keys (.i_press_g(press_g), .i_press_h(press_h),
      .i_out_g(out_g), .i_oe_n_g(oe_n_g), .i_out_h(out_h),
      .i_oe_n_h(oe_n_h), .i_pull_up_g(up_g), .i_pull_up_h(up_h),
      .o_pins_g(pins_g), .o_pins_h(pins_h));

   initial begin
      i_clock = 1'b0;
      forever #50 i_clock = ~i_clock;
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // one apb transfer; request held until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic err);
      int n;
      n = 0;
      @(posedge i_clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clock);
      penable <= 1'b1;
      do begin
         @(posedge i_clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         bad_count++;
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, {24'h0, d}, q, e);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q, {24'h0, exp});
   endtask : rd_chk

   task automatic wait_clk(input int n);
      repeat (n) @(posedge i_clock);
   endtask : wait_clk

   task automatic clear_flags();
      wr(OFS_FLAG_G, 8'hff);
      wr(OFS_FLAG_H, 8'hff);
   endtask : clear_flags

   task automatic t_regs();
      logic [7:0] offs [6];
      logic [31:0] q;
      logic e;
      offs = '{OFS_DIR_G, OFS_DIR_H, OFS_EN_G, OFS_EN_H, OFS_FLAG_G,
               OFS_FLAG_H};
      foreach (offs[i]) rd_chk(offs[i], RST_REG);
      wr(OFS_DIR_G, 8'ha5);
      wr(OFS_DIR_H, 8'h5a);
      rd_chk(OFS_DIR_G, 8'ha5);
      rd_chk(OFS_DIR_H, 8'h5a);
      chk(32'(oe_n_g), 32'h5a);
      chk(32'(oe_n_h), 32'ha5);
      apb(1'b1, 8'h40, 32'hff, q, e);
      chk(32'(e), 32'h1);
      apb(1'b0, 8'h40, 32'h0, q, e);
      chk(q, RD_ZERO);
      wr(OFS_DIR_G, 8'h00);
      wr(OFS_DIR_H, 8'h00);
      $display("test regs done");
   endtask : t_regs

   task automatic t_pull();
      sel_h <= 1'b0;
      wait_clk(2);
      chk(32'({up_g, dn_g, up_h, dn_h}), 32'h9);
      wait_clk(6);
      rd_chk(OFS_FLAG_H, 8'hff);
      sel_h <= 1'b1;
      wait_clk(6);
      clear_flags();
      $display("test pull done");
   endtask : t_pull

   task automatic t_edges();
      wr(OFS_EN_H, 8'h01);
      press_h <= 8'h01;
      wait_clk(6);
      rd_chk(OFS_FLAG_H, 8'h01);
      chk(32'(irq), 32'h1);
      wr(OFS_FLAG_H, 8'h00);
      rd_chk(OFS_FLAG_H, 8'h01);
      wr(OFS_FLAG_H, 8'h01);
      rd_chk(OFS_FLAG_H, 8'h00);
      chk(32'(irq), 32'h0);
      press_h <= 8'h00;
      wait_clk(6);
      rd_chk(OFS_FLAG_H, 8'h00);
      press_h <= 8'h02;
      wait_clk(6);
      rd_chk(OFS_FLAG_H, 8'h02);
      chk(32'(irq), 32'h0);
      press_h <= 8'h00;
      wait_clk(4);
      clear_flags();
      wr(OFS_EN_G, 8'h7f);
      wr(OFS_EN_H, 8'hff);
      press_g <= 8'hff;
      press_h <= 8'hff;
      wait_clk(6);
      rd_chk(OFS_FLAG_G, 8'h7f);
      rd_chk(OFS_FLAG_H, 8'hff);
      wr(OFS_FLAG_G, 8'hff);
      wait_clk(1);
      chk(32'(irq), 32'h1);
      wr(OFS_FLAG_H, 8'hff);
      wait_clk(1);
      chk(32'(irq), 32'h0);
      press_g <= 8'h00;
      press_h <= 8'h00;
      wait_clk(4);
      wr(OFS_EN_G, 8'h00);
      wr(OFS_EN_H, 8'h00);
      $display("test edges done");
   endtask : t_edges

   task automatic t_out_edge();
      wr(OFS_DATA_H, 8'h04);
      wr(OFS_DIR_H, 8'h04);
      wait_clk(4);
      clear_flags();
      wr(OFS_DATA_H, 8'h00);
      wait_clk(6);
      rd_chk(OFS_FLAG_H, 8'h04);
      wr(OFS_DIR_H, 8'h00);
      wait_clk(4);
      clear_flags();
      $display("test output edge done");
   endtask : t_out_edge

   task automatic t_start();
      wr(OFS_EN_G, 8'hc0);
      wr(OFS_DATA_G, 8'hc0);
      wr(OFS_DIR_G, 8'hc0);
      wait_clk(1);
      chk(32'(oe_n_g[7:6]), 32'h3);
      wr(OFS_DATA_G, 8'h80);
      wait_clk(1);
      chk(32'({out_g[7:6], oe_n_g[7:6]}), 32'h2);
      wait_clk(4);
      clear_flags();
      // hold scl low, then let sda rise and fall: no start may be seen
      press_g <= 8'h80;
      wr(OFS_DATA_G, 8'hc0);
      wait_clk(4);
      wr(OFS_DATA_G, 8'h80);
      wait_clk(6);
      rd_chk(OFS_FLAG_G, 8'h00);
      press_g <= 8'h00;
      wr(OFS_DATA_G, 8'hc0);
      wait_clk(6);
      clear_flags();
      press_g <= 8'h40;
      wait_clk(6);
      rd_chk(OFS_FLAG_G, 8'h40);
      chk(32'(irq), 32'h1);
      wr(OFS_EN_G, 8'h80);
      wait_clk(1);
      chk(32'(irq), 32'h0);
      press_g <= 8'h00;
      wr(OFS_EN_G, 8'h00);
      wr(OFS_DIR_G, 8'h00);
      wait_clk(4);
      clear_flags();
      $display("test start detect done");
   endtask : t_start

   task automatic t_stop();
      i_stop <= 1'b1;
      wr(OFS_EN_H, 8'h01);
      @(posedge i_clock);
      press_h <= 8'h01;
      #1;
      chk(32'(irq), 32'h1);
      @(posedge i_clock);
      press_h <= 8'h00;
      wait_clk(12);
      rd_chk(OFS_FLAG_H, 8'h00);
      press_h <= 8'h02;
      wait_clk(12);
      rd_chk(OFS_FLAG_H, 8'h00);
      press_h <= 8'h01;
      wait_clk(12);
      rd_chk(OFS_FLAG_H, 8'h01);
      press_h <= 8'h00;
      wait_clk(12);
      i_stop <= 1'b0;
      wr(OFS_EN_H, 8'h00);
      clear_flags();
      $display("test stop filter done");
   endtask : t_stop

   // watchdog: a hung handshake ends the run as a mismatch
   initial begin
      #5_000_000;
      bad_count++;
      wrap_up();
   end

   initial begin
      bad_count = 0;
      n_tests = 0;
      i_rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      i_stop = 1'b0;
      press_g = 8'h00;
      press_h = 8'h00;
      sel_g = 1'b1;
      sel_h = 1'b1;
      repeat (4) @(posedge i_clock);
      i_rst <= 1'b0;
      t_regs();
      t_pull();
      t_edges();
      t_out_edge();
      t_start();
      t_stop();
      wrap_up();
   end
endmodule : key_wakeup_ports_bench
`default_nettype wire
